//--- hdl/adc_params.svh
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
// ==========================================
// clock and timing
`define CLK_MHZ            200
`define T_CONV60_US        66600
`define T_CONV50_US        80000
`define T_CONVDUAL_US      72800
`define EXT_CONV_PERIODS   10278
`define EXT_MIN_HZ         2560
`define EXT_EDGES_PRESENT  2
`define SCK_DIV            8
`define INT_CONV_CLK_HZ    153600
// ==========================================
// result word layout
`define WORD_BITS          32
`define BIT_EOC            31
`define BIT_FILLER         30
`define BIT_POL            29
`define BIT_MSB            28
`define RES_LSB            5
`define SUB_MSB            4
`define FS_SUB_LSB         31'h10000000
`define CODE_ZERO          31'h20000000
// ==========================================
// reset values
`define RST_SHIFT          32'h00000000
`endif

//--- hdl/adc_pkg.sv
package adc_pkg;
  // ==========================================
  // result word carrier, first bit sent is eoc_n
  typedef struct packed {
    logic        eoc_n;
    logic        filler_bit;
    logic        polarity_bit;
    logic [23:0] result;
    logic [4:0]  sub_lsb;
  } result_word_s;
  // filter output in sub-lsb units, full scale is 2^28
  typedef logic signed [30:0] conv_value_t;
  // ==========================================
  // sequencer, gray coded along convert-sleep-data
  typedef enum logic [1:0] {
    ST_CONVERT = 2'b00,
    ST_SLEEP   = 2'b01,
    ST_DATA    = 2'b11
  } seq_state_e;
endpackage

//--- hdl/result_formatter.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_params.svh"
module result_formatter (
  // filter value
  input  wire adc_pkg::conv_value_t  value_i,
  // formatted word
  output adc_pkg::result_word_s      word_o
);
  // ==========================================
  // offset binary with clamping
  function automatic logic [29:0] clamp_code(input adc_pkg::conv_value_t v);
    logic [30:0] sum;
    sum = 31'(v) + `CODE_ZERO;
    if (v >= $signed(`FS_SUB_LSB)) begin
      clamp_code = 30'h30000000;
    end else if (v < -$signed(`FS_SUB_LSB)) begin
      clamp_code = 30'h0FFFFFFF;
    end else begin
      clamp_code = sum[29:0];
    end
  endfunction

  logic [29:0] code;
  always_comb begin
    code                = clamp_code(value_i);
    word_o.eoc_n        = 1'b0;
    word_o.filler_bit   = 1'b0;
    word_o.polarity_bit = code[`BIT_POL];
    word_o.result       = code[`BIT_MSB:`RES_LSB];
    word_o.sub_lsb      = code[`SUB_MSB:0];
  end
endmodule
`default_nettype wire

//--- hdl/word_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module word_buffer (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  // fill side
  input  wire logic                  in_valid_i,
  output logic                       in_ready_o,
  input  wire adc_pkg::result_word_s in_data_i,
  // drain side
  output logic                       out_valid_o,
  input  wire logic                  out_ready_i,
  output adc_pkg::result_word_s      out_data_o
);
  // ==========================================
  // two entries, so a stalled reader drops no word
  adc_pkg::result_word_s mem_q [2];
  adc_pkg::result_word_s mem_d [2];
  logic       wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic       push, pop;

  always_comb begin
    in_ready_o  = (cnt_q != 2'h2);
    out_valid_o = (cnt_q != 2'h0);
    out_data_o  = mem_q[rd_q];
    push        = in_valid_i & in_ready_o;
    pop         = out_valid_o & out_ready_i;
    mem_d       = mem_q;
    wr_d        = wr_q;
    rd_d        = rd_q;
    if (push) begin
      mem_d[wr_q] = in_data_i;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end
endmodule
`default_nettype wire

//--- hdl/adc_result_word_and_clock_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_params.svh"
// How it works
// - polarity and msb both high means overrange, both low underrange.
// - in range: positive gives 1/0, negative 0/1; eoc and filler read 0.
// - 24-bit result sits in word bits 28 to 5, msb first.
// - five sub-lsb bits sit in word bits 4 to 0.
// - chip select high: data pin floats, serial clock ignored.
// - host lowers chip select first; eoc shows on data pin at once.
// - with chip select low, eoc falls live when conversion ends.
// - bit 31 on first rise; bits 30..0 shift on falls 1..31.
// - 32nd fall drives data high, marking the next conversion.
// - out of range clamps to +fs or -fs-1lsb codes.
// - zero is 1 then zeros; minus one lsb is 0 then ones.
// - single notch: select low is 60 Hz, high is 50 Hz.
// - notch change only spoils the conversion in progress.
// - edges on select pin at 2560 Hz or more mean external clock.
// - external clock: notch at its frequency over 2560.
// - no external clock: back to internal oscillator timing.
// - source change during internal-clock output keeps data valid.
// - source change in sleep or external-clock output is harmless.
// - each result is one 32-bit word, eoc sent first.
// - internal serial clock is conversion clock divided by eight.
// - serial clock level at power-up or chip select fall picks mode.
// - conversion lasts 66.6 ms, 80 ms, 72.8 ms with dual notch, or 10278 external periods.
module adc_result_word_and_clock_select #(
  parameter int unsigned CONV60_CYC   = `T_CONV60_US * `CLK_MHZ,
  parameter int unsigned CONV50_CYC   = `T_CONV50_US * `CLK_MHZ,
  parameter int unsigned CONVDUAL_CYC = `T_CONVDUAL_US * `CLK_MHZ,
  parameter int unsigned EXT_PERIODS  = `EXT_CONV_PERIODS,
  parameter int unsigned EXT_TMO_CYC  = `CLK_MHZ * 1000000 / `EXT_MIN_HZ,
  parameter int unsigned SCK_HALF_CYC = `CLK_MHZ * 1000000 / (`INT_CONV_CLK_HZ / `SCK_DIV) / 2,
  parameter bit          DUAL_NOTCH   = 1'b0
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  // filter result, same clock
  input  wire adc_pkg::conv_value_t conv_value_i,
  // serial pins
  input  wire logic                cs_n_i,
  input  wire logic                sck_i,
  output logic                     sck_o,
  output logic                     sck_oe_o,
  output logic                     sdo_o,
  output logic                     sdo_oe_o,
  // conversion clock select pin
  input  wire logic                notch_select_pin_i,
  // status
  output logic                     ext_clk_mode_o,
  output logic                     int_sck_mode_o,
  output logic                     notch_50hz_o,
  output logic                     conv_busy_o
);
  // ==========================================
  // pin synchronisers; bit 0 is read only by bit 1
  logic [2:0] cs_s_q, sck_s_q, f0_s_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cs_s_q  <= 3'h7;
      sck_s_q <= 3'h7;
      f0_s_q  <= 3'h0;
    end else begin
      cs_s_q  <= {cs_s_q[1:0], cs_n_i};
      sck_s_q <= {sck_s_q[1:0], sck_i};
      f0_s_q  <= {f0_s_q[1:0], notch_select_pin_i};
    end
  end
  logic cs_low, cs_fall, cs_rise, f0_edge, f0_rise;
  assign cs_low  = ~cs_s_q[1];
  assign cs_fall = cs_s_q[2] & ~cs_s_q[1];
  assign cs_rise = ~cs_s_q[2] & cs_s_q[1];
  assign f0_edge = f0_s_q[2] ^ f0_s_q[1];
  assign f0_rise = ~f0_s_q[2] & f0_s_q[1];

  // ==========================================
  // conversion clock source detection
  logic        ext_q, ext_d;
  logic [16:0] tmo_q, tmo_d;
  logic [1:0]  edges_q, edges_d;
  logic        n50_q, n50_d;
  logic        ext_tick;
  always_comb begin
    ext_d   = ext_q;
    tmo_d   = tmo_q + 17'h1;
    edges_d = edges_q;
    if (f0_edge) begin
      tmo_d = 17'h0;
      if (edges_q != 2'(`EXT_EDGES_PRESENT)) begin
        edges_d = edges_q + 2'h1;
      end else begin
        ext_d = 1'b1;
      end
    end else if (tmo_q >= 17'(EXT_TMO_CYC - 1)) begin
      // a static level never toggles, so a quiet window means no clock
      tmo_d   = 17'h0;
      edges_d = 2'h0;
      ext_d   = 1'b0;
    end
    n50_d = ~DUAL_NOTCH & ~ext_d & f0_s_q[1];
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_q   <= 1'b0;
      tmo_q   <= 17'h0;
      edges_q <= 2'h0;
      n50_q   <= 1'b0;
    end else begin
      ext_q   <= ext_d;
      tmo_q   <= tmo_d;
      edges_q <= edges_d;
      n50_q   <= n50_d;
    end
  end
  assign ext_tick = ext_q & f0_rise;

  // ==========================================
  // conversion timing and result buffering
  adc_pkg::seq_state_e   state_q, state_d;
  adc_pkg::result_word_s fmt_word, buf_word;
  logic        run_q, run_d;
  logic [24:0] cnt_q, cnt_d;
  logic [24:0] target;
  logic        tick, at_end, push, buf_in_ready, buf_out_valid, pop;

  result_formatter u_fmt (
    .value_i (conv_value_i),
    .word_o  (fmt_word)
  );

  word_buffer u_buf (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (push),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (fmt_word),
    .out_valid_o (buf_out_valid),
    .out_ready_i (pop),
    .out_data_o  (buf_word)
  );

  always_comb begin
    // live select level: a change can stretch or shorten the running conversion
    if (ext_q) begin
      target = 25'(EXT_PERIODS);
    end else if (DUAL_NOTCH) begin
      target = 25'(CONVDUAL_CYC);
    end else if (n50_q) begin
      target = 25'(CONV50_CYC);
    end else begin
      target = 25'(CONV60_CYC);
    end
    tick   = ext_q ? ext_tick : 1'b1;
    at_end = tick & (cnt_q >= target - 25'h1);
    push   = run_q & at_end;
    pop    = (state_q == adc_pkg::ST_CONVERT) & buf_out_valid & ~run_q;
    run_d  = run_q;
    cnt_d  = cnt_q;
    if (run_q) begin
      if (at_end && buf_in_ready) begin
        run_d = 1'b0;
      end else if (tick && !at_end) begin
        cnt_d = cnt_q + 25'h1;
      end
    end else if (state_q == adc_pkg::ST_CONVERT && !buf_out_valid && buf_in_ready) begin
      // buffer back-pressure holds off the next conversion
      run_d = 1'b1;
      cnt_d = 25'h0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run_q <= 1'b0;
      cnt_q <= 25'h0;
    end else begin
      run_q <= run_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================
  // serial sequencer, clock generator and shifter
  logic [31:0] shift_q, shift_d;
  logic [5:0]  bits_q, bits_d;
  logic        isck_q, isck_d, sck_q, sck_d, sckoe_q, sckoe_d;
  logic        sdo_q, sdo_d, sdooe_q, sdooe_d;
  logic [12:0] half_q, half_d;
  logic [1:0]  div_q, div_d, pwr_q, pwr_d;
  logic        gen_on, half_end, sck_rise, sck_fall;
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bits_d  = bits_q;
    isck_d  = isck_q;
    half_d  = half_q;
    div_d   = div_q;
    pwr_d   = (pwr_q == 2'h3) ? pwr_q : pwr_q + 2'h1;
    if (pwr_q == 2'h2 || cs_fall) begin
      isck_d = sck_s_q[1];
    end
    gen_on = isck_q & cs_low & (state_q != adc_pkg::ST_CONVERT);
    // external source: eight conversion clocks per serial clock
    if (ext_q) begin
      half_end = ext_tick & (div_q == 2'(`SCK_DIV / 2 - 1));
    end else begin
      half_end = (half_q >= 13'(SCK_HALF_CYC - 1));
    end
    sck_d = sck_q;
    if (!gen_on) begin
      half_d = 13'h0;
      div_d  = 2'h0;
      if (!cs_low) begin
        sck_d = 1'b1;
      end
    end else begin
      half_d = half_end ? 13'h0 : half_q + 13'h1;
      div_d  = ext_tick ? div_q + 2'h1 : div_q;
      if (half_end) begin
        sck_d = ~sck_q;
      end
    end
    if (isck_q) begin
      sck_rise = gen_on & half_end & ~sck_q;
      sck_fall = gen_on & half_end & sck_q;
    end else begin
      sck_rise = cs_low & ~sck_s_q[2] & sck_s_q[1];
      sck_fall = cs_low & sck_s_q[2] & ~sck_s_q[1];
    end
    unique case (state_q)
      adc_pkg::ST_CONVERT: begin
        if (pop) begin
          state_d = adc_pkg::ST_SLEEP;
          shift_d = buf_word;
          bits_d  = 6'h0;
        end
      end
      adc_pkg::ST_SLEEP: begin
        if (sck_rise) begin
          state_d = adc_pkg::ST_DATA;
        end
      end
      adc_pkg::ST_DATA: begin
        if (cs_rise) begin
          state_d = adc_pkg::ST_CONVERT;
        end else if (sck_fall) begin
          shift_d = {shift_q[30:0], 1'b0};
          bits_d  = bits_q + 6'h1;
          if (bits_q == 6'(`WORD_BITS - 1)) begin
            state_d = adc_pkg::ST_CONVERT;
          end
        end
      end
      default: begin
        state_d = adc_pkg::ST_CONVERT;
      end
    endcase
    sckoe_d = isck_d & cs_low;
    sdooe_d = cs_low;
    sdo_d   = (state_d == adc_pkg::ST_CONVERT) ? 1'b1 : shift_d[`BIT_EOC];
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= adc_pkg::ST_CONVERT;
      shift_q <= `RST_SHIFT;
      bits_q  <= 6'h0;
      isck_q  <= 1'b1;
      sck_q   <= 1'b1;
      sckoe_q <= 1'b0;
      sdo_q   <= 1'b1;
      sdooe_q <= 1'b0;
      half_q  <= 13'h0;
      div_q   <= 2'h0;
      pwr_q   <= 2'h0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bits_q  <= bits_d;
      isck_q  <= isck_d;
      sck_q   <= sck_d;
      sckoe_q <= sckoe_d;
      sdo_q   <= sdo_d;
      sdooe_q <= sdooe_d;
      half_q  <= half_d;
      div_q   <= div_d;
      pwr_q   <= pwr_d;
    end
  end

  assign sck_o          = sck_q;
  assign sck_oe_o       = sckoe_q;
  assign sdo_o          = sdo_q;
  assign sdo_oe_o       = sdooe_q;
  assign ext_clk_mode_o = ext_q;
  assign int_sck_mode_o = isck_q;
  assign notch_50hz_o   = n50_q;
  assign conv_busy_o    = run_q;

  // ==========================================
  // checks
  property p_over_flags;
    @(posedge clk_i) disable iff (sys_rst_i)
      push && conv_value_i >= $signed(`FS_SUB_LSB) |-> fmt_word.polarity_bit && fmt_word.result[23];
  endproperty
  a_over_flags: assert property (p_over_flags) else $error("overrange flags wrong");

  property p_under_clamp;
    @(posedge clk_i) disable iff (sys_rst_i)
      push && conv_value_i < -$signed(`FS_SUB_LSB)
        |-> {fmt_word.polarity_bit, fmt_word.result, fmt_word.sub_lsb} == 30'h0FFFFFFF;
  endproperty
  a_under_clamp: assert property (p_under_clamp) else $error("underrange clamp wrong");

  property p_inrange_code;
    @(posedge clk_i) disable iff (sys_rst_i)
      push && conv_value_i >= -$signed(`FS_SUB_LSB) && conv_value_i < $signed(`FS_SUB_LSB)
        |-> {fmt_word.polarity_bit, fmt_word.result, fmt_word.sub_lsb}
            == 30'(31'(conv_value_i) + `CODE_ZERO) && fmt_word.polarity_bit != fmt_word.result[23];
  endproperty
  a_inrange_code: assert property (p_inrange_code) else $error("in-range code wrong");

  property p_status_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
      pop |=> !shift_q[`BIT_EOC] && !shift_q[`BIT_FILLER];
  endproperty
  a_status_zero: assert property (p_status_zero) else $error("eoc or filler not zero");

  property p_hiz;
    @(posedge clk_i) disable iff (sys_rst_i)
      cs_s_q[1] |=> !sdo_oe_o && !sck_oe_o;
  endproperty
  a_hiz: assert property (p_hiz) else $error("driving while deselected");

  property p_no_shift_deselected;
    @(posedge clk_i) disable iff (sys_rst_i)
      cs_s_q[1] && state_q != adc_pkg::ST_CONVERT |=> $stable(shift_q) && $stable(bits_q);
  endproperty
  a_no_shift_deselected: assert property (p_no_shift_deselected) else $error("shifted while deselected");

  property p_eoc_fall;
    @(posedge clk_i) disable iff (sys_rst_i)
      pop && cs_low |=> !sdo_o && sdo_oe_o ##1 (!sdo_o || state_q != adc_pkg::ST_SLEEP);
  endproperty
  a_eoc_fall: assert property (p_eoc_fall) else $error("eoc did not fall");

  property p_busy_high;
    @(posedge clk_i) disable iff (sys_rst_i)
      state_q == adc_pkg::ST_CONVERT && state_d == adc_pkg::ST_CONVERT && cs_low |=> sdo_o;
  endproperty
  a_busy_high: assert property (p_busy_high) else $error("eoc low during conversion");

  property p_shift_bit;
    @(posedge clk_i) disable iff (sys_rst_i)
      state_q == adc_pkg::ST_DATA && sck_fall && !cs_rise && bits_q != 6'h1F
        |=> sdo_o == $past(shift_q[30]) && bits_q == $past(bits_q) + 6'h1;
  endproperty
  a_shift_bit: assert property (p_shift_bit) else $error("bit not shifted on fall");

  property p_last_fall;
    @(posedge clk_i) disable iff (sys_rst_i)
      state_q == adc_pkg::ST_DATA && sck_fall && !cs_rise && bits_q == 6'h1F
        |=> state_q == adc_pkg::ST_CONVERT && sdo_o;
  endproperty
  a_last_fall: assert property (p_last_fall) else $error("32nd fall did not end word");

  property p_mode_pick;
    @(posedge clk_i) disable iff (sys_rst_i)
      cs_fall |=> int_sck_mode_o == $past(sck_s_q[1]);
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("serial clock mode not sampled");

  property p_conv_bound;
    @(posedge clk_i) disable iff (sys_rst_i)
      run_q && !ext_q && $stable(target) |-> cnt_q < target;
  endproperty
  a_conv_bound: assert property (p_conv_bound) else $error("conversion overran");

  property p_ext_lost;
    @(posedge clk_i) disable iff (sys_rst_i)
      !f0_edge && tmo_q >= 17'(EXT_TMO_CYC - 1) |=> !ext_clk_mode_o;
  endproperty
  a_ext_lost: assert property (p_ext_lost) else $error("external clock not dropped");

  c_full_word: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == adc_pkg::ST_DATA && sck_fall && bits_q == 6'h1F);
  c_abort: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == adc_pkg::ST_DATA && cs_rise);
  c_ext_mode: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(ext_q));
  c_buf_stall: cover property (@(posedge clk_i) disable iff (sys_rst_i) run_q && !buf_in_ready);
endmodule
`default_nettype wire

//--- sim/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host master on the three-wire link
module spi_host_model (
  // clock
  input  wire logic clk_i,
  // link
  output logic      cs_n_o,
  output logic      sck_drv_o,
  output logic      sck_en_o,
  input  wire logic sck_i,
  input  wire logic sdo_i
);
  logic [31:0] word_q;
  initial begin
    cs_n_o    = 1'b1;
    sck_drv_o = 1'b0;
    sck_en_o  = 1'b1;
    word_q    = 32'h00000000;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // sck level at the fall picks the mode; host sets sck two cycles before lowering cs
  task automatic select(input bit ext);
    sck_en_o  = ext;
    sck_drv_o = 1'b0;
    wait_clk(2);
    cs_n_o = 1'b0;
    wait_clk(6);
  endtask
  // sample before each rise; six-cycle phases clear the sync
  task automatic shift_ext(input int nbits);
    for (int i = 0; i < nbits; i++) begin
      word_q    = {word_q[30:0], sdo_i};
      sck_drv_o = 1'b1;
      wait_clk(6);
      sck_drv_o = 1'b0;
      wait_clk(6);
    end
  endtask
  // device clocks; sample at each rise, report last low phase
  task automatic shift_int(output int lo);
    int t;
    t  = 0;
    lo = 0;
    for (int i = 0; i < 32; i++) begin
      while (sck_i !== 1'b0 && t < 2000) begin
        wait_clk(1);
        t++;
      end
      lo = 0;
      while (sck_i !== 1'b1 && t < 2000) begin
        wait_clk(1);
        t++;
        lo++;
      end
      word_q = {word_q[30:0], sdo_i};
    end
  endtask
  task automatic release_cs();
    cs_n_o = 1'b1;
    wait_clk(4);
  endtask
endmodule
`default_nettype wire

//--- sim/test_adc_result_word_and_clock_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_result_word_and_clock_select;
  localparam int C60 = 200;
  localparam int C50 = 300;
  localparam int EXTP = 20;
  localparam int HALF = 8;
  logic                 clk_i;
  logic                 sys_rst_i;
  logic                 notch;
  logic                 ext_run;
  logic                 sdo_last;
  adc_pkg::conv_value_t value;
  logic                 sck_o;
  logic                 sck_oe;
  logic                 sdo_o;
  logic                 sdo_oe;
  logic                 ext_mode;
  logic                 int_mode;
  logic                 n50;
  logic                 busy;
  logic                 cs_n;
  logic                 sck_drv;
  logic                 sck_en;
  wire logic            sck_w;
  wire logic            sdo_w;
  int                   num_errors;
  int                   num_checks;
  int                   n;
  logic signed [31:0]   vals [10];
  // released sck floats high; a floating sdo shows the inverse of its last bit
  assign sck_w = sck_oe ? sck_o : (sck_en ? sck_drv : 1'b1);
  assign sdo_w = sdo_oe ? sdo_o : ~sdo_last;
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (sdo_oe) sdo_last <= sdo_o;
  // external conversion clock, period 20 cycles, well under the timeout
  initial begin
    forever begin
      repeat (10) @(posedge clk_i);
      #1;
      if (ext_run) notch = ~notch;
    end
  end
  adc_result_word_and_clock_select #(
    .CONV60_CYC  (C60),
    .CONV50_CYC  (C50),
    .EXT_PERIODS (EXTP),
    .EXT_TMO_CYC (64),
    .SCK_HALF_CYC(HALF)
  ) adc_result_word_and_clock_select_inst (
    .clk_i             (clk_i),
    .sys_rst_i         (sys_rst_i),
    .conv_value_i      (value),
    .cs_n_i            (cs_n),
    .sck_i             (sck_w),
    .sck_o             (sck_o),
    .sck_oe_o          (sck_oe),
    .sdo_o             (sdo_o),
    .sdo_oe_o          (sdo_oe),
    .notch_select_pin_i(notch),
    .ext_clk_mode_o    (ext_mode),
    .int_sck_mode_o    (int_mode),
    .notch_50hz_o      (n50),
    .conv_busy_o       (busy)
  );
  spi_host_model spi_host_model_inst (
    .clk_i    (clk_i),
    .cs_n_o   (cs_n),
    .sck_drv_o(sck_drv),
    .sck_en_o (sck_en),
    .sck_i    (sck_w),
    .sdo_i    (sdo_w)
  );
  // ==========================================
  // helpers
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_n(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic wait_busy(input logic lvl, output int cnt);
    cnt = 0;
    while (busy !== lvl) begin
      spi_host_model_inst.wait_clk(1);
      cnt++;
      if (cnt > 5000) begin
        num_errors++;
        $display("wrong value busy wait expected %b seen timeout", lvl);
        stop_test();
      end
    end
  endtask
  // abort in data state restarts conversion; time the one that follows
  task automatic conv_len(output int cnt);
    wait_busy(1'b0, cnt);
    spi_host_model_inst.select(1'b1);
    spi_host_model_inst.shift_ext(1);
    spi_host_model_inst.release_cs();
    wait_busy(1'b1, cnt);
    wait_busy(1'b0, cnt);
  endtask
  function automatic logic [31:0] expect_word(input logic signed [31:0] v);
    if (v >= 32'sh10000000) return 32'h30000000;
    if (v < -32'sh10000000) return 32'h0FFFFFFF;
    return 32'(v + 32'sh20000000);
  endfunction
  // ==========================================
  // main sequence
  initial begin
    sys_rst_i = 1'b1;
    value = '0;
    notch = 1'b0;
    ext_run = 1'b0;
    sdo_last = 1'b0;
    num_errors = 0;
    num_checks = 0;
    vals = '{32'sh0, -32'sh1, 32'sh5, 32'sh0FFFFFFF, 32'sh10000000, 32'sh3FFFFFFF,
             -32'sh10000000, -32'sh10000001, -32'sh40000000, 32'sh08000000};
    repeat (5) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    check("sdo_oe after reset", 32'h0, sdo_oe);
    check("int mode after reset", 32'h1, int_mode);
    spi_host_model_inst.wait_clk(4);
    check("power-up sck mode", 32'h0, int_mode);
    spi_host_model_inst.select(1'b1);
    check("eoc while converting", 32'h1, sdo_w);
    wait_busy(1'b0, n);
    spi_host_model_inst.wait_clk(4);
    check("eoc after conversion", 32'h0, sdo_w);
    check("ext sck mode", 32'h0, int_mode);
    // sleep holds until a word is read, so read it to restart conversions
    spi_host_model_inst.shift_ext(32);
    check("first word", expect_word(32'sh0), spi_host_model_inst.word_q);
    spi_host_model_inst.release_cs();
    $display("test eoc done");
    for (int i = 0; i < 10; i++) begin
      value = 31'(vals[i]);
      wait_busy(1'b1, n);
      wait_busy(1'b0, n);
      if (i == 0) begin
        spi_host_model_inst.shift_ext(5);
        check("sdo_oe with cs high", 32'h0, sdo_oe);
      end
      spi_host_model_inst.select(1'b1);
      spi_host_model_inst.shift_ext(32);
      check("result word", expect_word(vals[i]), spi_host_model_inst.word_q);
      check("sdo after 32nd fall", 32'h1, sdo_w);
      spi_host_model_inst.release_cs();
    end
    $display("test word format done");
    value = 31'h00ABCDE0;
    wait_busy(1'b1, n);
    wait_busy(1'b0, n);
    spi_host_model_inst.select(1'b0);
    check("int sck mode", 32'h1, int_mode);
    check("sck driven in int mode", 32'h1, sck_oe);
    spi_host_model_inst.shift_int(n);
    check_n("sck low phase", HALF, HALF, n);
    check("internal sck word", 32'h20ABCDE0, spi_host_model_inst.word_q);
    spi_host_model_inst.release_cs();
    $display("test internal sck done");
    conv_len(n);
    check_n("60 Hz conversion", C60 - 2, C60 + 2, n);
    notch = 1'b1;
    conv_len(n);
    check("50 Hz flag", 32'h1, n50);
    check_n("50 Hz conversion", C50 - 2, C50 + 2, n);
    notch = 1'b0;
    conv_len(n);
    check_n("back to 60 Hz", C60 - 2, C60 + 2, n);
    $display("test notch done");
    ext_run = 1'b1;
    spi_host_model_inst.wait_clk(100);
    check("ext clock seen", 32'h1, ext_mode);
    conv_len(n);
    check_n("ext conversion", EXTP * 20 - 25, EXTP * 20 + 25, n);
    ext_run = 1'b0;
    spi_host_model_inst.wait_clk(2);
    notch = 1'b0;
    spi_host_model_inst.wait_clk(300);
    check("ext clock dropped", 32'h0, ext_mode);
    conv_len(n);
    check_n("internal again", C60 - 2, C60 + 2, n);
    $display("test conversion clock done");
    stop_test();
  end
endmodule
`default_nettype wire
